//--- design/iara_core.sv
`timescale 1ns/1ns
// Contract
// - Read: 0xD0, address low then high, repeated start read, data low then high.
// - Write: 0xD0, address low/high, data low/high, each acked, then stop.
// - PEC byte follows the high data byte only when PEC is enabled.
// - Direction 0 write, 1 read; ack is 0, nack is 1.
// - Register 0x005C bit 1 forces continuous conduction; resets to 1.
// - Register 0x0040 bits 14:8 hold secondary address, reset 0x10, permit-gated.
// - Register 0x0040 bits 6:0 hold management address 0x40; zero disables interface.
// - Register 0x00D4 bit 2 permits address changes; resets to 1.
// - Register 0x005E bit 15 picks overvoltage source; 1 uses relative code.
// - Bits 14:12 relative overvoltage code, reset 3, 50mV steps, doubled at half scale.
// - Register 0x0060 bits 2:0 fixed overvoltage code, reset 6, code 7 reserved.
// - Register 0x005E bit 11 picks undervoltage source; 1 uses relative code.
// - Bits 10:8 relative undervoltage code, reset 3, 50mV steps, doubled at half scale.
// - Advanced fields reachable only through the indirect command, 16-bit address and data.
module iara_core (
  // core clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // management link pins, scl is the link clock
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // link and threshold options
  input  wire logic        pec_enable,
  input  wire logic        half_sense_scale,
  input  wire logic [15:0] standard_overvolt_limit,
  input  wire logic [15:0] standard_undervolt_limit,
  // decoded controls
  output logic             force_ccm,
  output logic [6:0]       active_mgmt_addr,
  output logic [6:0]       active_sec_addr,
  output logic             mgmt_enabled,
  output logic [15:0]      ov_threshold_mv,
  output logic [15:0]      uv_threshold_mv,
  output logic             fixed_code_reserved,
  output logic [15:0]      fixed_ov_mv
);
  import iara_pkg::*;

  typedef enum {
    ST_IDLE, ST_ADDR, ST_CMD, ST_RA_LO, ST_RA_HI, ST_WD_LO, ST_WD_HI, ST_WPEC,
    ST_RADDR, ST_RD_LO, ST_RD_HI, ST_RPEC, ST_IGNORE
  } iara_state_t;

  typedef struct packed {
    iara_state_t state;
    logic [2:0]  st_s, sp_s, by_s;
    logic [2:0]  pend;
    logic [7:0]  pend_sel;
    logic [15:0] reg_addr;
    logic [7:0]  wlo;
    logic        ack_en;
    logic        tx_en;
    logic [7:0]  tx_byte;
    logic        ccm;
    logic [6:0]  sec_addr, mgmt_addr;
    logic [6:0]  act_sec, act_mgmt;
    logic        addr_dirty;
    logic        permit;
    logic        ov_src, uv_src;
    logic [2:0]  ov_code, uv_code, fixed_code;
    logic        pec_s1, pec_s2;
  } iara_core_t;

  iara_core_t c_reg, c_next;

  logic       st_tgl, sp_tgl, by_tgl;
  logic [7:0] rx_byte;

  iara_byte_link u_link (
    .scl       (scl),
    .sda_in    (sda_in),
    .rst_b     (rst_b),
    .start_tgl (st_tgl),
    .stop_tgl  (sp_tgl),
    .byte_tgl  (by_tgl),
    .byte_data (rx_byte),
    .ack_en    (c_reg.ack_en),
    .tx_en     (c_reg.tx_en),
    .tx_byte   (c_reg.tx_byte),
    .sda_oe    (sda_oe)
  );

  // indirect register read mux, unmapped offsets read zero
  function automatic logic [15:0] rd_word(input iara_core_t c);
    logic [15:0] w;
    w = 16'h0000;
    case (c.reg_addr)
      IARA_BUS_ADDRESS_PAIR: begin
        w[IARA_SEC_ADDR_LSB +: 7]  = c.sec_addr;
        w[IARA_MGMT_ADDR_LSB +: 7] = c.mgmt_addr;
      end
      IARA_LIGHT_LOAD_CTRL: w[IARA_CCM_BIT] = c.ccm;
      IARA_RELATIVE_PROT: begin
        w[IARA_OV_SRC_BIT]         = c.ov_src;
        w[IARA_OV_CODE_LSB +: 3]   = c.ov_code;
        w[IARA_UV_SRC_BIT]         = c.uv_src;
        w[IARA_UV_CODE_LSB +: 3]   = c.uv_code;
      end
      IARA_FIXED_OV_CTRL:   w[IARA_FIXED_CODE_LSB +: 3] = c.fixed_code;
      IARA_ADDR_PERMIT:     w[IARA_PERMIT_BIT] = c.permit;
      default:              w = 16'h0000;
    endcase
    return w;
  endfunction

  // relative code to millivolts, step doubles at half scale
  function automatic logic [15:0] rel_mv(input logic [2:0] code, input logic half);
    logic [15:0] mv;
    mv = 16'((32'(code) + 32'd1) * IARA_REL_STEP_MV);
    return half ? {mv[14:0], 1'b0} : mv;
  endfunction

  // fixed overvoltage table, reserved code reads as zero
  function automatic logic [15:0] fixed_mv(input logic [2:0] code, input logic half);
    logic [15:0] mv;
    case (code)
      3'h0:    mv = IARA_FIXED_MV_0;
      3'h1:    mv = IARA_FIXED_MV_1;
      3'h2:    mv = IARA_FIXED_MV_2;
      3'h3:    mv = IARA_FIXED_MV_3;
      3'h4:    mv = IARA_FIXED_MV_4;
      3'h5:    mv = IARA_FIXED_MV_5;
      3'h6:    mv = IARA_FIXED_MV_6;
      default: mv = 16'h0000;
    endcase
    return half ? {mv[14:0], 1'b0} : mv;
  endfunction

  logic        st_ev, sp_ev, by_ev;
  logic [15:0] rword;

  always_comb begin
    c_next = c_reg;
    // two-flop crossing of the link toggles, third stage for edge detect
    c_next.st_s   = {c_reg.st_s[1:0], st_tgl};
    c_next.sp_s   = {c_reg.sp_s[1:0], sp_tgl};
    c_next.by_s   = {c_reg.by_s[1:0], by_tgl};
    c_next.pec_s1 = pec_enable;
    c_next.pec_s2 = c_reg.pec_s1;
    st_ev = c_reg.st_s[2] ^ c_reg.st_s[1];
    sp_ev = c_reg.sp_s[2] ^ c_reg.sp_s[1];
    by_ev = c_reg.by_s[2] ^ c_reg.by_s[1];
    rword = rd_word(c_reg);

    if (sp_ev) begin
      c_next.state  = ST_IDLE;
      c_next.ack_en = 1'b0;
      c_next.tx_en  = 1'b0;
      if (c_reg.addr_dirty) begin
        c_next.act_sec    = c_reg.sec_addr;
        c_next.act_mgmt   = c_reg.mgmt_addr;
        c_next.addr_dirty = 1'b0;
      end
    end else if (st_ev) begin
      // a repeated start after the address pointer turns to a read
      c_next.state = (c_reg.state == ST_RADDR) ? ST_RADDR : ST_ADDR;
      c_next.ack_en = 1'b0;
      c_next.tx_en  = 1'b0;
    end else if (by_ev) begin
      c_next.ack_en = 1'b0;
      c_next.tx_en  = 1'b0;
      case (c_reg.state)
        ST_ADDR, ST_RADDR: begin
          // zero management address leaves the interface deaf
          if (c_reg.act_mgmt != 7'h00 && rx_byte[7:1] == c_reg.act_mgmt) begin
            c_next.ack_en = 1'b1;
            if (rx_byte[0] == IARA_DIR_READ && c_reg.state == ST_RADDR) begin
              c_next.state   = ST_RD_LO;
              c_next.tx_en   = 1'b1;
              c_next.tx_byte = rword[7:0];
            end else if (rx_byte[0] == IARA_DIR_WRITE) begin
              c_next.state = ST_CMD;
            end else begin
              c_next.ack_en = 1'b0;
              c_next.state  = ST_IGNORE;
            end
          end else begin
            c_next.state = ST_IGNORE;
          end
        end
        ST_CMD: begin
          // only the indirect command is served here
          c_next.ack_en = (rx_byte == IARA_CMD_INDIRECT);
          c_next.state  = (rx_byte == IARA_CMD_INDIRECT) ? ST_RA_LO : ST_IGNORE;
        end
        ST_RA_LO: begin
          c_next.reg_addr[7:0] = rx_byte;
          c_next.ack_en        = 1'b1;
          c_next.state         = ST_RA_HI;
        end
        ST_RA_HI: begin
          c_next.reg_addr[15:8] = rx_byte;
          c_next.ack_en         = 1'b1;
          c_next.state          = ST_WD_LO;
        end
        ST_WD_LO: begin
          c_next.wlo    = rx_byte;
          c_next.ack_en = 1'b1;
          c_next.state  = ST_WD_HI;
        end
        ST_WD_HI: begin
          c_next.ack_en = 1'b1;
          c_next.state  = c_reg.pec_s2 ? ST_WPEC : ST_IGNORE;
          case (c_reg.reg_addr)
            IARA_BUS_ADDRESS_PAIR: begin
              if (c_reg.permit) begin
                c_next.sec_addr   = rx_byte[IARA_SEC_ADDR_LSB - 8 +: 7];
                c_next.mgmt_addr  = c_reg.wlo[IARA_MGMT_ADDR_LSB +: 7];
                c_next.addr_dirty = 1'b1;
              end
            end
            IARA_LIGHT_LOAD_CTRL: c_next.ccm = c_reg.wlo[IARA_CCM_BIT];
            IARA_RELATIVE_PROT: begin
              c_next.ov_src  = rx_byte[IARA_OV_SRC_BIT - 8];
              c_next.ov_code = rx_byte[IARA_OV_CODE_LSB - 8 +: 3];
              c_next.uv_src  = rx_byte[IARA_UV_SRC_BIT - 8];
              c_next.uv_code = rx_byte[IARA_UV_CODE_LSB - 8 +: 3];
            end
            IARA_FIXED_OV_CTRL: c_next.fixed_code = c_reg.wlo[IARA_FIXED_CODE_LSB +: 3];
            IARA_ADDR_PERMIT:   c_next.permit = c_reg.wlo[IARA_PERMIT_BIT];
            default:            c_next.permit = c_reg.permit;
          endcase
        end
        ST_WPEC: begin
          // pec is acknowledged but not checked
          c_next.ack_en = 1'b1;
          c_next.state  = ST_IGNORE;
        end
        ST_RD_LO: begin
          // host ack of the low byte is not tracked; high byte follows
          c_next.tx_en   = 1'b1;
          c_next.tx_byte = rword[15:8];
          c_next.state   = ST_RD_HI;
        end
        ST_RD_HI: begin
          c_next.tx_en   = c_reg.pec_s2;
          c_next.tx_byte = 8'h00;
          c_next.state   = c_reg.pec_s2 ? ST_RPEC : ST_IGNORE;
        end
        default: c_next.state = ST_IGNORE;
      endcase
      // after the high address byte a repeated start may follow
      if (c_reg.state == ST_RA_HI) c_next.state = ST_WD_LO;
    end
    if (st_ev && c_reg.state == ST_WD_LO) c_next.state = ST_RADDR;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      c_reg            <= '0;
      c_reg.state      <= ST_IDLE;
      c_reg.ccm        <= IARA_CCM_RST;
      c_reg.sec_addr   <= IARA_SEC_ADDR_RST;
      c_reg.mgmt_addr  <= IARA_MGMT_ADDR_RST;
      c_reg.act_sec    <= IARA_SEC_ADDR_RST;
      c_reg.act_mgmt   <= IARA_MGMT_ADDR_RST;
      c_reg.permit     <= IARA_PERMIT_RST;
      c_reg.ov_src     <= IARA_OV_SRC_RST;
      c_reg.ov_code    <= IARA_OV_CODE_RST;
      c_reg.uv_src     <= IARA_UV_SRC_RST;
      c_reg.uv_code    <= IARA_UV_CODE_RST;
      c_reg.fixed_code <= IARA_FIXED_CODE_RST;
    end else begin
      c_reg <= c_next;
    end
  end

  assign sda_out          = 1'b0;
  assign force_ccm        = c_reg.ccm;
  assign active_mgmt_addr = c_reg.act_mgmt;
  assign active_sec_addr  = c_reg.act_sec;
  assign mgmt_enabled     = (c_reg.act_mgmt != 7'h00);
  assign fixed_ov_mv      = fixed_mv(c_reg.fixed_code, half_sense_scale);
  assign fixed_code_reserved = (c_reg.fixed_code == IARA_FIXED_RESERVED);
  assign ov_threshold_mv  = c_reg.ov_src ? rel_mv(c_reg.ov_code, half_sense_scale)
                                         : standard_overvolt_limit;
  assign uv_threshold_mv  = c_reg.uv_src ? rel_mv(c_reg.uv_code, half_sense_scale)
                                         : standard_undervolt_limit;
endmodule // iara_core

//--- design/iara_pkg.sv
package iara_pkg;
  // bus encoding
  localparam logic [7:0]  IARA_CMD_INDIRECT      = 8'hd0;
  localparam logic        IARA_DIR_WRITE         = 1'b0;
  localparam logic        IARA_DIR_READ          = 1'b1;
  localparam logic        IARA_ACK               = 1'b0;
  localparam logic        IARA_NACK              = 1'b1;
  // indirect register offsets
  localparam logic [15:0] IARA_BUS_ADDRESS_PAIR  = 16'h0040;
  localparam logic [15:0] IARA_LIGHT_LOAD_CTRL   = 16'h005c;
  localparam logic [15:0] IARA_RELATIVE_PROT     = 16'h005e;
  localparam logic [15:0] IARA_FIXED_OV_CTRL     = 16'h0060;
  localparam logic [15:0] IARA_ADDR_PERMIT       = 16'h00d4;
  // field positions
  localparam int          IARA_CCM_BIT           = 1;
  localparam int          IARA_SEC_ADDR_LSB      = 8;
  localparam int          IARA_MGMT_ADDR_LSB     = 0;
  localparam int          IARA_PERMIT_BIT        = 2;
  localparam int          IARA_OV_SRC_BIT        = 15;
  localparam int          IARA_OV_CODE_LSB       = 12;
  localparam int          IARA_UV_SRC_BIT        = 11;
  localparam int          IARA_UV_CODE_LSB       = 8;
  localparam int          IARA_FIXED_CODE_LSB    = 0;
  // reset values
  localparam logic        IARA_CCM_RST           = 1'b1;
  localparam logic [6:0]  IARA_SEC_ADDR_RST      = 7'h10;
  localparam logic [6:0]  IARA_MGMT_ADDR_RST     = 7'h40;
  localparam logic        IARA_PERMIT_RST        = 1'b1;
  localparam logic        IARA_OV_SRC_RST        = 1'b1;
  localparam logic [2:0]  IARA_OV_CODE_RST       = 3'h3;
  localparam logic        IARA_UV_SRC_RST        = 1'b1;
  localparam logic [2:0]  IARA_UV_CODE_RST       = 3'h3;
  localparam logic [2:0]  IARA_FIXED_CODE_RST    = 3'h6;
  localparam logic [2:0]  IARA_FIXED_RESERVED    = 3'h7;
  // relative threshold step and fixed threshold values in mV
  localparam int          IARA_REL_STEP_MV       = 50;
  localparam logic [15:0] IARA_FIXED_MV_0        = 16'd800;
  localparam logic [15:0] IARA_FIXED_MV_1        = 16'd1000;
  localparam logic [15:0] IARA_FIXED_MV_2        = 16'd1200;
  localparam logic [15:0] IARA_FIXED_MV_3        = 16'd1350;
  localparam logic [15:0] IARA_FIXED_MV_4        = 16'd1500;
  localparam logic [15:0] IARA_FIXED_MV_5        = 16'd1800;
  localparam logic [15:0] IARA_FIXED_MV_6        = 16'd2200;
endpackage

//--- design/iara_byte_link.sv
`timescale 1ns/1ns
// bit-level slave on the link clock domain: start/stop detection, byte shift, ack drive
module iara_byte_link (
  // link pins, sampled in the link domain
  input  wire logic       scl,
  input  wire logic       sda_in,
  input  wire logic       rst_b,
  // frame events, each a toggle for the core domain, and the last received byte
  output logic            start_tgl,
  output logic            stop_tgl,
  output logic            byte_tgl,
  output logic [7:0]      byte_data,
  // ack and data the core asks for, held stable around the edge of use
  input  wire logic       ack_en,
  input  wire logic       tx_en,
  input  wire logic [7:0] tx_byte,
  output logic            sda_oe
);
  import iara_pkg::*;

  typedef struct packed {
    logic [3:0] cnt;
    logic [7:0] sh;
    logic       byte_t;
    logic       in_ack;
    logic [7:0] data;
  } iara_bl_t;

  iara_bl_t s_reg, s_next;
  logic     start_reg, stop_reg;

  // start and stop show as sda edges while scl is high
  always_ff @(negedge sda_in or negedge rst_b) begin
    if (!rst_b) start_reg <= 1'b0;
    else if (scl) start_reg <= ~start_reg;
  end
  always_ff @(posedge sda_in or negedge rst_b) begin
    if (!rst_b) stop_reg <= 1'b0;
    else if (scl) stop_reg <= ~stop_reg;
  end
  assign start_tgl = start_reg;
  assign stop_tgl  = stop_reg;

  logic st_seen_reg, st_prev_reg;
  always_ff @(posedge scl or negedge rst_b) begin
    if (!rst_b) st_prev_reg <= 1'b0;
    else st_prev_reg <= start_reg;
  end
  assign st_seen_reg = st_prev_reg ^ start_reg;

  always_comb begin
    s_next = s_reg;
    if (st_seen_reg) begin
      s_next.cnt    = 4'h1;
      s_next.sh     = {7'h00, sda_in};
      s_next.in_ack = 1'b0;
    end else if (s_reg.cnt == 4'h8) begin
      s_next.cnt    = 4'h0;
      s_next.in_ack = 1'b1;
    end else begin
      s_next.in_ack = 1'b0;
      s_next.cnt    = s_reg.cnt + 4'h1;
      s_next.sh     = {s_reg.sh[6:0], sda_in};
      if (s_reg.cnt == 4'h7) begin
        s_next.data   = {s_reg.sh[6:0], sda_in};
        s_next.byte_t = ~s_reg.byte_t;
      end
    end
  end

  always_ff @(posedge scl or negedge rst_b) begin
    if (!rst_b) s_reg <= '0;
    else s_reg <= s_next;
  end
  assign byte_tgl  = s_reg.byte_t;
  assign byte_data = s_reg.data;

  // output changes on the falling edge so the host samples it stable
  logic [2:0] bitpos;
  logic       drive_reg;
  assign bitpos = 3'(4'h7 - s_reg.cnt);
  always_ff @(negedge scl or negedge rst_b) begin
    if (!rst_b) drive_reg <= 1'b0;
    else if (s_reg.cnt == 4'h8) drive_reg <= ack_en;
    else if (tx_en && s_reg.cnt < 4'h8) drive_reg <= ~tx_byte[bitpos];
    else drive_reg <= 1'b0;
  end
  assign sda_oe = drive_reg;
endmodule // iara_byte_link

//--- verif/iara_asserts.sv
`timescale 1ns/1ns
module iara_asserts (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // link pins
  input wire logic        scl,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  // options
  input wire logic        half_sense_scale,
  input wire logic [15:0] standard_overvolt_limit,
  input wire logic [15:0] standard_undervolt_limit,
  // decoded controls
  input wire logic        force_ccm,
  input wire logic [6:0]  active_mgmt_addr,
  input wire logic [6:0]  active_sec_addr,
  input wire logic        mgmt_enabled,
  input wire logic [15:0] ov_threshold_mv,
  input wire logic [15:0] uv_threshold_mv,
  input wire logic        fixed_code_reserved,
  input wire logic [15:0] fixed_ov_mv
);
  import iara_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // relative codes give (n+1) steps; the bench keeps standard limits off this grid
  function automatic logic rel_ok(logic [15:0] mv, logic half);
    int s;
    s = half ? 2 * IARA_REL_STEP_MV : IARA_REL_STEP_MV;
    return mv >= s && mv <= 8 * s && mv % s == 0;
  endfunction
  function automatic logic fix_ok(logic [15:0] mv, logic half);
    logic [15:0] b;
    b = half ? mv >> 1 : mv;
    return (!half || !mv[0]) && b inside {IARA_FIXED_MV_0, IARA_FIXED_MV_1, IARA_FIXED_MV_2,
      IARA_FIXED_MV_3, IARA_FIXED_MV_4, IARA_FIXED_MV_5, IARA_FIXED_MV_6};
  endfunction
  sequence s_bus_idle;
    scl && sda_in;
  endsequence
  property p_rst_vals;
    $rose(rst_b) |-> force_ccm && active_mgmt_addr == IARA_MGMT_ADDR_RST && active_sec_addr == IARA_SEC_ADDR_RST;
  endproperty
  property p_mgmt_en; mgmt_enabled == (active_mgmt_addr != 7'h00); endproperty
  property p_mgmt_quiet; !mgmt_enabled |-> !sda_oe; endproperty
  property p_mgmt_at_stop; $changed(active_mgmt_addr) |-> s_bus_idle; endproperty
  property p_sec_at_stop; $changed(active_sec_addr) |-> s_bus_idle; endproperty
  property p_oe_scl_low; $changed(sda_oe) |-> !scl; endproperty
  property p_oe_hold_high; scl && $past(scl) |-> $stable(sda_oe); endproperty
  property p_od_low; sda_out == 1'b0; endproperty
  property p_ov_rel; ov_threshold_mv != standard_overvolt_limit |-> rel_ok(ov_threshold_mv, half_sense_scale);
  endproperty
  property p_uv_rel; uv_threshold_mv != standard_undervolt_limit |-> rel_ok(uv_threshold_mv, half_sense_scale);
  endproperty
  property p_fixed; fixed_code_reserved ? fixed_ov_mv == 16'h0000 : fix_ok(fixed_ov_mv, half_sense_scale);
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
  a_mgmt_en: assert property (p_mgmt_en) else $error("mgmt enable mismatch");
  a_mgmt_quiet: assert property (p_mgmt_quiet) else $error("disabled interface drives");
  a_mgmt_at_stop: assert property (p_mgmt_at_stop) else $error("mgmt addr moved mid frame");
  a_sec_at_stop: assert property (p_sec_at_stop) else $error("sec addr moved mid frame");
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data changed with scl high");
  a_oe_hold_high: assert property (p_oe_hold_high) else $error("data moved while scl high");
  a_od_low: assert property (p_od_low) else $error("open drain level not low");
  a_ov_rel: assert property (p_ov_rel) else $error("ov threshold off grid");
  a_uv_rel: assert property (p_uv_rel) else $error("uv threshold off grid");
  a_fixed: assert property (p_fixed) else $error("fixed ov value wrong");
endmodule // iara_asserts

//--- verif/iara_host_model.sv
`timescale 1ns/1ns
// management host: drives scl, pulls data low; scl idles high between frames
module iara_host_model #(
  parameter int Q = 287
) (
  // host pins
  output logic      scl,
  output logic      sda_pull,
  // resolved data line
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // start from idle, or repeated start from scl low
  task automatic start();
    #Q sda_pull = 1'b0;
    #Q scl = 1'b1;
    #(2*Q) sda_pull = 1'b1;
    #(2*Q) scl = 1'b0;
  endtask
  // idle gap after stop lets the core settle before the next start
  task automatic stop();
    #Q sda_pull = 1'b1;
    #Q scl = 1'b1;
    #(2*Q) sda_pull = 1'b0;
    #(4*Q);
  endtask
  task automatic clk_bit(input logic b, output logic s);
    #Q sda_pull = ~b;
    #Q scl = 1'b1;
    #Q s = sda;
    #Q scl = 1'b0;
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, ack);
  endtask
  task automatic get(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, b[i]);
    end
    clk_bit(nack, s);
  endtask
endmodule // iara_host_model

//--- verif/indirect_advanced_register_access_tb.sv
`timescale 1ns/1ns
module indirect_advanced_register_access_tb;
  import iara_pkg::*;
  logic        clk;
  logic        rst_b;
  logic        scl;
  logic        sda_pull;
  logic        sda_oe;
  logic        sda_out;
  wire         sda;
  logic        pec_enable;
  logic        half_sense_scale;
  logic [15:0] std_ov;
  logic [15:0] std_uv;
  logic        force_ccm;
  logic [6:0]  mgmt_addr;
  logic [6:0]  sec_addr;
  logic        mgmt_en;
  logic [15:0] ov_mv;
  logic [15:0] uv_mv;
  logic        fix_res;
  logic [15:0] fix_mv;
  logic [6:0]  dev;
  logic [15:0] rdata;
  int          fail_count;
  int          tests_run;
  // pull-up on the data line
  assign sda = !(sda_oe || sda_pull);
  always #50 clk = ~clk;
  iara_core u_dut (.clk(clk), .rst_b(rst_b), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .pec_enable(pec_enable), .half_sense_scale(half_sense_scale), .standard_overvolt_limit(std_ov),
    .standard_undervolt_limit(std_uv), .force_ccm(force_ccm), .active_mgmt_addr(mgmt_addr),
    .active_sec_addr(sec_addr), .mgmt_enabled(mgmt_en), .ov_threshold_mv(ov_mv), .uv_threshold_mv(uv_mv),
    .fixed_code_reserved(fix_res), .fixed_ov_mv(fix_mv));
  iara_host_model u_host (.scl(scl), .sda_pull(sda_pull), .sda(sda));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] want);
    tests_run++;
    if (seen !== want) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, want, seen);
    end
  endtask
  task automatic head(input logic [15:0] a, input logic [7:0] c, input logic n0, input logic n);
    logic [7:0] b [4];
    logic       ak;
    b = '{{dev, IARA_DIR_WRITE}, c, a[7:0], a[15:8]};
    u_host.start();
    foreach (b[i]) begin
      u_host.put(b[i], ak);
      check("head_ack", ak, i == 0 ? n0 : n);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic n);
    logic [6:0] held;
    logic       ak;
    held = mgmt_addr;
    head(a, IARA_CMD_INDIRECT, n, n);
    u_host.put(d[7:0], ak);
    check("wr_lo_ack", ak, n);
    u_host.put(d[15:8], ak);
    check("wr_hi_ack", ak, n);
    if (pec_enable) begin
      u_host.put(8'h00, ak);
      check("wr_pec_ack", ak, n);
    end
    check("addr_held", mgmt_addr, held);
    u_host.stop();
  endtask
  task automatic rd(input logic [15:0] a, input logic n);
    logic       ak;
    logic [7:0] p;
    head(a, IARA_CMD_INDIRECT, n, n);
    u_host.start();
    u_host.put({dev, IARA_DIR_READ}, ak);
    check("rd_ack", ak, n);
    if (!n) begin
      u_host.get(1'b0, rdata[7:0]);
      u_host.get(!pec_enable, rdata[15:8]);
      if (pec_enable) begin
        u_host.get(1'b1, p);
        check("pec_slot", p, 8'h00);
      end
    end
    u_host.stop();
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] m, input logic [15:0] want);
    rd(a, 1'b0);
    check("reg_read", rdata & m, want);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #6000000;
    fail_count++;
    $display("watchdog expired");
    final_report();
  end
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    pec_enable = 1'b0;
    half_sense_scale = 1'b0;
    std_ov = 16'd1234;
    std_uv = 16'd567;
    dev = IARA_MGMT_ADDR_RST;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    check("ccm_rst", force_ccm, IARA_CCM_RST);
    check("sec_rst", sec_addr, IARA_SEC_ADDR_RST);
    check("ov_rst", ov_mv, 16'd200);
    check("uv_rst", uv_mv, 16'd200);
    check("fix_rst", fix_mv, IARA_FIXED_MV_6);
    rd_chk(IARA_LIGHT_LOAD_CTRL, 16'h0002, 16'h0002);
    rd_chk(IARA_BUS_ADDRESS_PAIR, 16'h7f7f, 16'h1040);
    rd_chk(IARA_RELATIVE_PROT, 16'hff00, 16'hbb00);
    rd_chk(IARA_FIXED_OV_CTRL, 16'h0007, 16'h0006);
    rd_chk(IARA_ADDR_PERMIT, 16'h0004, 16'h0004);
    $display("test reset_values done");
    wr(IARA_LIGHT_LOAD_CTRL, 16'h0000, 1'b0);
    check("ccm_off", force_ccm, 1'b0);
    wr(IARA_LIGHT_LOAD_CTRL, 16'h0002, 1'b0);
    check("ccm_on", force_ccm, 1'b1);
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      half_sense_scale <= c[1];
      wr(IARA_RELATIVE_PROT, {1'b1, c[2:0], 1'b1, c[2:0], 8'h00}, 1'b0);
      check("ov_rel", ov_mv, 16'((c + 1) * IARA_REL_STEP_MV * (c / 2 % 2 + 1)));
      check("uv_rel", uv_mv, 16'((c + 1) * IARA_REL_STEP_MV * (c / 2 % 2 + 1)));
    end
    wr(IARA_RELATIVE_PROT, 16'h0000, 1'b0);
    check("ov_std", ov_mv, std_ov);
    check("uv_std", uv_mv, std_uv);
    $display("test thresholds done");
    @(posedge clk);
    half_sense_scale <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      wr(IARA_FIXED_OV_CTRL, 16'(c), 1'b0);
      check("fix_res", fix_res, c == 7);
      check("fix_mv", fix_mv, c == 7 ? 16'h0000 : 16'(800 + (c > 0) * 200 + (c > 1) * 200 + (c > 2) * 150
        + (c > 3) * 150 + (c > 4) * 300 + (c > 5) * 400));
    end
    @(posedge clk);
    half_sense_scale <= 1'b1;
    wr(IARA_FIXED_OV_CTRL, 16'h0006, 1'b0);
    check("fix_half", fix_mv, 16'd4400);
    $display("test fixed done");
    @(posedge clk);
    pec_enable <= 1'b1;
    wr(IARA_LIGHT_LOAD_CTRL, 16'h0000, 1'b0);
    rd_chk(IARA_LIGHT_LOAD_CTRL, 16'h0002, 16'h0000);
    @(posedge clk);
    pec_enable <= 1'b0;
    $display("test pec done");
    // host keeps to non-reserved secondary addresses
    wr(IARA_BUS_ADDRESS_PAIR, 16'h1122, 1'b0);
    check("mgmt_new", mgmt_addr, 7'h22);
    check("sec_new", sec_addr, 7'h11);
    rd(IARA_LIGHT_LOAD_CTRL, 1'b1);
    dev = 7'h22;
    wr(IARA_ADDR_PERMIT, 16'h0000, 1'b0);
    wr(IARA_BUS_ADDRESS_PAIR, 16'h3355, 1'b0);
    check("mgmt_locked", mgmt_addr, 7'h22);
    rd_chk(IARA_BUS_ADDRESS_PAIR, 16'h7f7f, 16'h1122);
    wr(16'h0070, 16'hffff, 1'b0);
    rd_chk(16'h0070, 16'hffff, 16'h0000);
    head(IARA_LIGHT_LOAD_CTRL, 8'hd1, 1'b0, 1'b1);
    u_host.stop();
    wr(IARA_ADDR_PERMIT, 16'h0004, 1'b0);
    wr(IARA_BUS_ADDRESS_PAIR, 16'h1100, 1'b0);
    check("mgmt_off", mgmt_en, 1'b0);
    rd(IARA_LIGHT_LOAD_CTRL, 1'b1);
    $display("test addresses done");
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    check("mgmt_rerst", mgmt_addr, IARA_MGMT_ADDR_RST);
    $display("test second_reset done");
    final_report();
  end
endmodule // indirect_advanced_register_access_tb
bind iara_core iara_asserts u_chk (.clk(clk), .rst_b(rst_b), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .half_sense_scale(half_sense_scale), .standard_overvolt_limit(standard_overvolt_limit),
  .standard_undervolt_limit(standard_undervolt_limit), .force_ccm(force_ccm), .active_mgmt_addr(active_mgmt_addr),
  .active_sec_addr(active_sec_addr), .mgmt_enabled(mgmt_enabled), .ov_threshold_mv(ov_threshold_mv),
  .uv_threshold_mv(uv_threshold_mv), .fixed_code_reserved(fixed_code_reserved), .fixed_ov_mv(fixed_ov_mv));
